/* hw/fid_pkg.sv */
package fid_pkg;
  // instruction word and program counter widths
  localparam int IW = 14;
  localparam int PCW = 13;
  // four oscillator periods make one instruction cycle
  localparam int QPH = 4;
  // special file addresses
  localparam logic [6:0] F_TMR = 7'h01;
  localparam logic [6:0] F_STAT = 7'h03;
  localparam logic [6:0] F_PORT = 7'h06;
  // fixed control encodings
  localparam logic [IW-1:0] I_NOP = 14'h0000;
  localparam logic [6:0] E_RETURN = 7'h08;
  localparam logic [6:0] E_RETFIE = 7'h09;
  localparam logic [6:0] E_SLEEP = 7'h63;
  localparam logic [6:0] E_CLRWDT = 7'h64;
  // bus register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_PC = 8'h08;
  localparam logic [7:0] A_TMR = 8'h0C;
  // control register fields
  localparam int C_RUN = 0;
  localparam int C_PSA = 1;
  localparam int C_PS = 2;
  localparam int C_WAKE = 5;
  localparam int C_OE = 8;
  localparam logic [15:0] CTRL_RST = 16'h0003;
  // status register fields
  localparam int S_ST = 8;
  localparam int S_PCF = 16;
  localparam int S_SLP = 17;
  // status byte bits
  localparam int B_C = 0;
  localparam int B_DC = 1;
  localparam int B_Z = 2;
  localparam int B_PD = 3;
  localparam int B_TO = 4;
  localparam logic [4:0] ST_POR = 5'h18;

  typedef enum logic [1:0] {grp_byte, grp_bit, grp_lit} fid_grp_t;

  typedef enum logic [5:0] {
    op_nop, op_movwf, op_clr, op_subwf, op_decf, op_iorwf, op_andwf, op_xorwf,
    op_addwf, op_movf, op_comf, op_incf, op_decfsz, op_rrf, op_rlf, op_swapf,
    op_incfsz, op_bcf, op_bsf, op_btfsc, op_btfss, op_call, op_goto, op_movlw,
    op_retlw, op_iorlw, op_andlw, op_xorlw, op_sublw, op_addlw, op_return,
    op_retfie, op_sleep, op_clrwdt
  } fid_op_t;

  typedef enum logic [1:0] {ph_read, ph_mod, ph_exec, ph_fetch} fid_ph_t;

  // returns {carry, digit carry, sum}
  function automatic logic [9:0] fid_add(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {full[8], lo[4], full[7:0]};
  endfunction
endpackage

/* hw/fid_sync.sv */
`timescale 1ns/1ps
module fid_sync (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] d,
  output logic [7:0] q
);
  typedef struct packed {
    logic [7:0] m1;
    logic [7:0] m2;
    logic [7:0] m3;
    logic [7:0] q;
  } fid_sync_st_t;

  fid_sync_st_t s;
  fid_sync_st_t next_s;
  logic [7:0] agree;

  always_comb begin
    next_s = s;
    next_s.m1 = d;
    next_s.m2 = s.m1;
    next_s.m3 = s.m2;
    agree = ~(s.m2 ^ s.m3);
    next_s.q = (s.q & ~agree) | (s.m3 & agree);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;
endmodule // fid_sync

/* hw/fid_decode.sv */
`timescale 1ns/1ps
module fid_decode (
  input wire logic [fid_pkg::IW-1:0] ir,
  output fid_pkg::fid_grp_t grp,
  output fid_pkg::fid_op_t op,
  output logic d,
  output logic [6:0] f,
  output logic [2:0] bsel,
  output logic [7:0] k8,
  output logic [10:0] k11,
  output logic nf
);
  import fid_pkg::*;

  assign d = ir[7];
  assign f = ir[6:0];
  assign bsel = ir[9:7];
  assign k8 = ir[7:0];
  assign k11 = ir[10:0];

  always_comb begin
    grp = grp_byte;
    op = op_nop;
    case (ir[13:12])
      2'b00: begin
        if (ir[11:7] == 5'b00000) begin
          grp = grp_lit;
          case (ir[6:0])
            E_SLEEP: op = op_sleep;
            E_CLRWDT: op = op_clrwdt;
            E_RETURN: op = op_return;
            E_RETFIE: op = op_retfie;
            default: op = op_nop;
          endcase
        end else begin
          case (ir[11:8])
            4'h0: op = op_movwf;
            4'h1: op = op_clr;
            4'h2: op = op_subwf;
            4'h3: op = op_decf;
            4'h4: op = op_iorwf;
            4'h5: op = op_andwf;
            4'h6: op = op_xorwf;
            4'h7: op = op_addwf;
            4'h8: op = op_movf;
            4'h9: op = op_comf;
            4'hA: op = op_incf;
            4'hB: op = op_decfsz;
            4'hC: op = op_rrf;
            4'hD: op = op_rlf;
            4'hE: op = op_swapf;
            default: op = op_incfsz;
          endcase
        end
      end
      2'b01: begin
        grp = grp_bit;
        case (ir[11:10])
          2'b00: op = op_bcf;
          2'b01: op = op_bsf;
          2'b10: op = op_btfsc;
          default: op = op_btfss;
        endcase
      end
      2'b10: begin
        grp = grp_lit;
        op = ir[11] ? op_goto : op_call;
      end
      default: begin
        grp = grp_lit;
        case (ir[11:8])
          4'h0, 4'h1, 4'h2, 4'h3: op = op_movlw;
          4'h4, 4'h5, 4'h6, 4'h7: op = op_retlw;
          4'h8: op = op_iorlw;
          4'h9: op = op_andlw;
          4'hA: op = op_xorlw;
          4'hC, 4'hD: op = op_sublw;
          4'hE, 4'hF: op = op_addlw;
          default: op = op_nop;
        endcase
      end
    endcase
    // clearing the accumulator names no file register
    nf = (grp == grp_bit) || (grp == grp_byte && !(op == op_clr && !ir[7]));
  end
endmodule // fid_decode

/* hw/fid_core.sv */
`timescale 1ns/1ps
// How it works
// - each instruction is one 14-bit word: opcode plus operand fields
// - every word falls in exactly one group: byte, bit, or literal/control
// - byte ops: d=0 sends result to accumulator, d=1 back to file
// - the 7-bit file address reaches locations 0x00 to 0x7F of one bank
// - bit ops pick one bit of the addressed 8-bit file register
// - literal ops use an 8-bit constant or an 11-bit jump target
// - one instruction cycle is four clock phases
// - one cycle per instruction; taken skip or jump adds a no-op cycle
// - file register is read first, then modified, then stored
// - reading the port, even to clear it, refreshes the change latch
// - don't-care bits are ignored when decoding
// - byte format: opcode on top, d in bit 7, file address below
// - standby word 0x0063 takes one cycle and sets time-out, clears power-down
// - port reads sample synchronised pin levels, not the output latch
// - writing the timer clears the prescaler when it is assigned to it
module fid_core (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [fid_pkg::PCW-1:0] prog_addr,
  input wire logic [fid_pkg::IW-1:0] prog_word,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe
);
  import fid_pkg::*;

  typedef struct packed {
    fid_ph_t ph;
    logic [PCW-1:0] pc;
    logic [PCW-1:0] tgt;
    logic [IW-1:0] ir;
    logic [7:0] w;
    logic [4:0] st;
    logic [7:0] tmr;
    logic [7:0] pre;
    logic [7:0] lat;
    logic [3:0] cmp;
    logic pcf;
    logic slp;
    logic flush;
    logic skip;
    logic [2:0] sp;
    logic [7:0] rdat;
    logic [15:0] ctrl;
    logic wpend;
    logic [7:0] waddr;
    logic [31:0] rdata;
    logic rdy;
    logic resp;
  } fid_core_st_t;

  localparam fid_core_st_t ST_RST = '{
    ph: ph_read,
    ir: I_NOP,
    st: ST_POR,
    ctrl: CTRL_RST,
    rdy: 1'b1,
    default: '0
  };

  fid_core_st_t s;
  fid_core_st_t next_s;
  logic [1:0] rsync;
  logic rst_n;

  logic [7:0] mem [0:127];
  logic [PCW-1:0] stk [0:7];
  logic mem_we;
  logic [7:0] mem_d;
  logic stk_we;

  fid_grp_t grp;
  fid_op_t op;
  logic d;
  logic [6:0] f;
  logic [2:0] bsel;
  logic [7:0] k8;
  logic [10:0] k11;
  logic nf;
  logic [7:0] pins;

  logic [7:0] src;
  logic [7:0] res;
  logic [9:0] sum;
  logic [8:0] ptop;
  logic wf;
  logic ww;
  logic zf;
  logic cf;
  logic tk;
  logic jmp;
  logic bus_go;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rsync <= 2'b00;
    end else begin
      rsync <= {rsync[0], 1'b1};
    end
  end
  assign rst_n = rsync[1];

  fid_decode u_dec (
    .ir(s.ir),
    .grp(grp),
    .op(op),
    .d(d),
    .f(f),
    .bsel(bsel),
    .k8(k8),
    .k11(k11),
    .nf(nf)
  );

  fid_sync u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(port_b_in),
    .q(pins)
  );

  always_comb begin
    next_s = s;
    mem_we = 1'b0;
    mem_d = 8'h00;
    stk_we = 1'b0;
    src = (grp == grp_lit) ? k8 : s.rdat;
    res = src;
    sum = 10'h000;
    wf = (grp == grp_byte) & d;
    ww = (grp == grp_byte) & ~d;
    zf = 1'b0;
    cf = 1'b0;
    tk = 1'b0;
    jmp = 1'b0;
    ptop = (9'h002 << s.ctrl[C_PS +: 3]) - 9'h001;
    bus_go = hsel & hready & htrans[1];

    // bus write data phase
    if (s.wpend) begin
      case (s.waddr)
        A_CTRL: begin
          next_s.ctrl = hwdata[15:0];
          if (hwdata[C_WAKE]) begin
            next_s.slp = 1'b0;
          end
        end
        A_STAT: begin
          if (hwdata[S_PCF]) begin
            next_s.pcf = 1'b0;
          end
        end
        default: ;
      endcase
    end
    next_s.wpend = bus_go & hwrite;
    next_s.waddr = haddr;
    if (bus_go & ~hwrite) begin
      case (haddr)
        A_CTRL: next_s.rdata = {16'h0000, s.ctrl};
        A_STAT: next_s.rdata = {14'h0000, s.slp, s.pcf, 3'b000, s.st, s.w};
        A_PC: next_s.rdata = {2'b00, s.ir, 3'b000, s.pc};
        A_TMR: next_s.rdata = {16'h0000, s.pre, s.tmr};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end

    // port change flag, set wins over a clear
    if (pins[7:4] != s.cmp) begin
      next_s.pcf = 1'b1;
    end
    if (s.pcf) begin
      next_s.slp = 1'b0;
    end

    // instruction cycle: halts only on a cycle boundary
    if (s.ph != ph_read || (s.ctrl[C_RUN] && !s.slp)) begin
      case (s.ph)
        ph_read: begin
          next_s.ph = ph_mod;
          if (nf) begin
            case (f)
              F_TMR: next_s.rdat = s.tmr;
              F_STAT: next_s.rdat = {3'b000, s.st};
              F_PORT: begin
                next_s.rdat = pins;
                next_s.cmp = pins[7:4];
              end
              default: next_s.rdat = mem[f];
            endcase
          end
        end
        ph_mod: begin
          next_s.ph = ph_exec;
        end
        ph_exec: begin
          next_s.ph = ph_fetch;
          case (op)
            op_movwf: res = s.w;
            op_clr: begin
              res = 8'h00;
              zf = 1'b1;
            end
            op_subwf, op_sublw: begin
              sum = fid_add(src, ~s.w, 1'b1);
              res = sum[7:0];
              zf = 1'b1;
              cf = 1'b1;
              ww = ww | (op == op_sublw);
            end
            op_addwf, op_addlw: begin
              sum = fid_add(src, s.w, 1'b0);
              res = sum[7:0];
              zf = 1'b1;
              cf = 1'b1;
              ww = ww | (op == op_addlw);
            end
            op_andwf, op_andlw: begin
              res = src & s.w;
              zf = 1'b1;
              ww = ww | (op == op_andlw);
            end
            op_iorwf, op_iorlw: begin
              res = src | s.w;
              zf = 1'b1;
              ww = ww | (op == op_iorlw);
            end
            op_xorwf, op_xorlw: begin
              res = src ^ s.w;
              zf = 1'b1;
              ww = ww | (op == op_xorlw);
            end
            op_movf: zf = 1'b1;
            op_comf: begin
              res = ~src;
              zf = 1'b1;
            end
            op_incf, op_incfsz: begin
              res = src + 8'h01;
              zf = (op == op_incf);
              tk = (op == op_incfsz) && (res == 8'h00);
            end
            op_decf, op_decfsz: begin
              res = src - 8'h01;
              zf = (op == op_decf);
              tk = (op == op_decfsz) && (res == 8'h00);
            end
            op_rrf: begin
              res = {s.st[B_C], src[7:1]};
              next_s.st[B_C] = src[0];
            end
            op_rlf: begin
              res = {src[6:0], s.st[B_C]};
              next_s.st[B_C] = src[7];
            end
            op_swapf: res = {src[3:0], src[7:4]};
            op_bcf, op_bsf: begin
              res[bsel] = (op == op_bsf);
              wf = 1'b1;
            end
            op_btfsc: tk = ~src[bsel];
            op_btfss: tk = src[bsel];
            op_call: begin
              stk_we = 1'b1;
              next_s.sp = s.sp + 3'h1;
              next_s.tgt = {2'b00, k11};
              jmp = 1'b1;
            end
            op_goto: begin
              next_s.tgt = {2'b00, k11};
              jmp = 1'b1;
            end
            op_movlw, op_retlw: begin
              ww = 1'b1;
              if (op == op_retlw) begin
                next_s.sp = s.sp - 3'h1;
                next_s.tgt = stk[s.sp - 3'h1];
                jmp = 1'b1;
              end
            end
            op_return, op_retfie: begin
              next_s.sp = s.sp - 3'h1;
              next_s.tgt = stk[s.sp - 3'h1];
              jmp = 1'b1;
            end
            op_sleep: begin
              next_s.st[B_TO] = 1'b1;
              next_s.st[B_PD] = 1'b0;
              next_s.slp = 1'b1;
            end
            op_clrwdt: begin
              next_s.st[B_TO] = 1'b1;
              next_s.st[B_PD] = 1'b1;
            end
            default: ;
          endcase
          if (wf) begin
            case (f)
              F_TMR: begin
                next_s.tmr = res;
                if (!s.ctrl[C_PSA]) begin
                  next_s.pre = 8'h00;
                end
              end
              F_STAT: next_s.st[2:0] = res[2:0];
              F_PORT: next_s.lat = res;
              default: begin
                mem_we = 1'b1;
                mem_d = res;
              end
            endcase
          end
          if (ww) begin
            next_s.w = res;
          end
          if (zf) begin
            next_s.st[B_Z] = (res == 8'h00);
          end
          if (cf) begin
            next_s.st[B_C] = sum[9];
            next_s.st[B_DC] = sum[8];
          end
          next_s.flush = tk | jmp;
          next_s.skip = tk;
        end
        ph_fetch: begin
          next_s.ph = ph_read;
          next_s.flush = 1'b0;
          next_s.skip = 1'b0;
          if (s.flush) begin
            next_s.ir = I_NOP;
            if (s.skip) begin
              next_s.pc = s.pc + 13'h0001;
            end else begin
              next_s.pc = s.tgt;
            end
          end else begin
            next_s.ir = prog_word;
            next_s.pc = s.pc + 13'h0001;
          end
          if (s.ctrl[C_PSA]) begin
            next_s.tmr = s.tmr + 8'h01;
          end else if ({1'b0, s.pre} >= ptop) begin
            next_s.pre = 8'h00;
            next_s.tmr = s.tmr + 8'h01;
          end else begin
            next_s.pre = s.pre + 8'h01;
          end
        end
        default: next_s.ph = ph_read;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= ST_RST;
    end else begin
      s <= next_s;
    end
  end

  // file register and return stack storage
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[f] <= mem_d;
    end
    if (stk_we) begin
      stk[s.sp] <= s.pc;
    end
  end

  assign hrdata = s.rdata;
  assign hreadyout = s.rdy;
  assign hresp = s.resp;
  assign prog_addr = s.pc;
  assign port_b_out = s.lat;
  assign port_b_oe = s.ctrl[C_OE +: 8];
endmodule // fid_core

/* test/fid_prog_model.sv */
`timescale 1ns/1ps
module fid_prog_model (
  input wire logic [fid_pkg::PCW-1:0] prog_addr,
  output logic [fid_pkg::IW-1:0] prog_word
);
  import fid_pkg::*;
  logic [IW-1:0] mem [2**PCW];
  // word 0 parks the core in a loop; unloaded words are no-ops
  initial foreach (mem[i]) mem[i] = (i == 0) ? 14'h2800 : I_NOP;
  assign prog_word = mem[prog_addr];
endmodule // fid_prog_model

/* test/fid_core_sva.sv */
`timescale 1ns/1ps
module fid_core_sva (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [fid_pkg::PCW-1:0] prog_addr,
  input wire logic [fid_pkg::IW-1:0] prog_word,
  input wire logic [7:0] port_b_oe
);
  import fid_pkg::*;
  logic take;
  logic [2:0] dp;
  assign take = hsel && hready && htrans[1];
  // data phase markers: ctrl write, pc read, unmapped read
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dp <= 3'b000;
    end else begin
      dp <= {take && hwrite && haddr == A_CTRL, take && !hwrite && haddr == A_PC,
        take && !hwrite && haddr > 8'h0F};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // a goto or call taken in by a plain sequential fetch
  sequence jmp;
    prog_addr == $past(prog_addr) + 13'd1 && $past(prog_word[13:12]) == 2'b10;
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  fetch_spacing_a: assert property (
    $changed(prog_addr) |=> $stable(prog_addr) [*3])
    else $error("fetch sooner than one instruction cycle");
  jump_target_a: assert property (
    jmp |-> ##4 prog_addr[10:0] == $past(prog_word[10:0], 5))
    else $error("jump target not reached after one cycle");
  jump_discard_a: assert property (
    jmp |-> ##8 prog_addr[10:0] == $past(prog_word[10:0], 9) + 11'd1)
    else $error("jump did not insert one no-op cycle");
  pc_read_a: assert property (dp[1] |-> hrdata[PCW-1:0] == $past(prog_addr))
    else $error("pc read differs from fetch address");
  unmapped_read_a: assert property (dp[0] |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  oe_write_a: assert property (dp[2] |=> port_b_oe == $past(hwdata[15:8]))
    else $error("drive enable not taken from ctrl write");
  oe_hold_a: assert property ($changed(port_b_oe) |-> $past(dp[2]))
    else $error("drive enable changed without ctrl write");
  c_jump: cover property (jmp);
  c_ctrl: cover property (dp[2]);
  c_pc: cover property (dp[1]);
  c_unmapped: cover property (dp[0]);
endmodule // fid_core_sva

bind fid_core fid_core_sva chk (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .prog_addr(prog_addr), .prog_word(prog_word),
  .port_b_oe(port_b_oe));

/* test/test_fid_core.sv */
`timescale 1ns/1ps
module test_fid_core;
  import fid_pkg::*;
  logic clk_sys, nrst, hsel, hwrite, hreadyout, hresp;
  logic [7:0] haddr, port_b_in, port_b_out, port_b_oe;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [PCW-1:0] prog_addr;
  logic [IW-1:0] prog_word;
  int n_errors, comparisons, halt;
  fid_core dut (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .prog_addr(prog_addr), .prog_word(prog_word),
    .port_b_in(port_b_in), .port_b_out(port_b_out), .port_b_oe(port_b_oe));
  fid_prog_model pm (.prog_addr(prog_addr), .prog_word(prog_word));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic w_is(input logic [7:0] e);
    bus(1'b0, A_STAT, 32'h0, rd);
    check(32'(rd[7:0]), 32'(e));
  endtask
  task automatic park();
    for (int i = 0; i < 4000 && prog_addr !== halt[PCW-1:0]; i++) @(posedge clk_sys);
    if (prog_addr !== halt[PCW-1:0]) begin
      n_errors++;
      $display("BAD %0t program never reached its end", $time);
    end
    repeat (12) @(posedge clk_sys);
  endtask
  // load code after the parking loop, then redirect the loop to it
  task automatic run(input logic [13:0] c[$], input bit wait_end);
    int s;
    #1;
    s = halt + 2;
    foreach (c[i]) pm.mem[s + i] = c[i];
    halt = s + c.size();
    pm.mem[halt] = 14'h2800 | 14'(halt);
    pm.mem[halt + 1] = 14'h30EE;
    pm.mem[s - 2] = 14'h2800 | 14'(s);
    if (wait_end) park();
  endtask
  task automatic t_bus();
    bus(1'b0, A_CTRL, 32'h0, rd);
    check(rd, {16'h0000, CTRL_RST});
    bus(1'b0, A_STAT, 32'h0, rd);
    check(32'(rd[12:0]), 32'({ST_POR, 8'h00}));
    bus(1'b1, 8'h40, 32'hFFFF_FFFF, rd);
    bus(1'b0, 8'h40, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b1, A_CTRL, 32'h0000_A503, rd);
    #1;
    check(32'(port_b_oe), 32'h0000_00A5);
    bus(1'b1, A_CTRL, 32'h0000_0003, rd);
    bus(1'b0, A_PC, 32'h0, rd);
  endtask
  task automatic t_sleep();
    bus(1'b1, A_STAT, 32'h0001_0000, rd);
    run('{14'h0063, I_NOP}, 1'b0);
    repeat (40) @(posedge clk_sys);
    bus(1'b0, A_STAT, 32'h0, rd);
    check(32'({rd[17], rd[12:11]}), 32'h6);
    bus(1'b1, A_CTRL, 32'h0000_0023, rd);
    park();
    bus(1'b0, A_STAT, 32'h0, rd);
    check(32'(rd[17]), 32'h0);
    bus(1'b1, A_CTRL, 32'h0000_0003, rd);
  endtask
  task automatic t_lit();
    run('{14'h33A5, 14'h3F01, 14'h3A0F, 14'h39F0}, 1'b1);
    w_is(8'hA0);
  endtask
  task automatic t_dest();
    run('{14'h3005, 14'h00FF, 14'h3003, 14'h077F}, 1'b1);
    w_is(8'h08);
    run('{14'h07FF}, 1'b1);
    w_is(8'h08);
    run('{14'h087F}, 1'b1);
    w_is(8'h0D);
  endtask
  task automatic t_bit();
    logic [13:0] bb;
    for (int b = 0; b < 8; b++) begin
      bb = 14'(b) << 7;
      run('{14'h01A0, 14'h1420 | bb, 14'h0820, 14'h1C20 | bb, 14'h30EE, 14'h1820 | bb,
        14'h3AFF}, 1'b1);
      w_is(~(8'h01 << b));
    end
  endtask
  task automatic t_call();
    pm.mem['h700] = 14'h345A;
    run('{14'h2700}, 1'b1);
    w_is(8'h5A);
  endtask
  task automatic t_port();
    port_b_in <= 8'h3C;
    repeat (5) @(posedge clk_sys);
    run('{14'h30FF, 14'h0086, 14'h0806}, 1'b1);
    w_is(8'h3C);
    check(32'(port_b_out), 32'hFF);
    bus(1'b1, A_STAT, 32'h0001_0000, rd);
    bus(1'b0, A_STAT, 32'h0, rd);
    check(32'(rd[16]), 32'h0);
    port_b_in <= 8'h5C;
    repeat (10) @(posedge clk_sys);
    bus(1'b0, A_STAT, 32'h0, rd);
    check(32'(rd[16]), 32'h1);
    run('{14'h0186}, 1'b1);
    bus(1'b1, A_STAT, 32'h0001_0000, rd);
    bus(1'b0, A_STAT, 32'h0, rd);
    check(32'(rd[16]), 32'h0);
    check(32'(port_b_out), 32'h0);
  endtask
  task automatic t_timer();
    bus(1'b1, A_CTRL, 32'h0000_001D, rd);
    repeat (400) @(posedge clk_sys);
    run('{14'h3040, 14'h0081}, 1'b1);
    bus(1'b0, A_TMR, 32'h0, rd);
    check(32'(rd[7:0]), 32'h40);
    check(32'(rd[15:8] < 8'd40), 32'h1);
    bus(1'b1, A_CTRL, 32'h0000_0003, rd);
  endtask
  initial begin
    #200_000;
    n_errors++;
    end_of_test();
  end
  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hsize = 3'b010;
    hwdata = 32'h0;
    port_b_in = 8'h00;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_bus();
    t_sleep();
    t_lit();
    t_dest();
    t_bit();
    t_call();
    t_port();
    t_timer();
    end_of_test();
  end
endmodule // test_fid_core
